// >>> rtl/abu_pkg.sv
// Package for the address breakpoint unit: register map, fields, reset values
package abu_pkg;
    localparam logic [7:0] ABU_OFF_WAIT_STATUS = 8'h00;
    localparam logic [7:0] ABU_OFF_FLAG_CLEAR = 8'h03;
    localparam logic [7:0] ABU_OFF_ADDR_HIGH = 8'h09;
    localparam logic [7:0] ABU_OFF_ADDR_LOW = 8'h0A;
    localparam logic [7:0] ABU_OFF_STATUS_CTRL = 8'h0B;
    localparam int ABU_BIT_ENABLE = 7;
    localparam int ABU_BIT_ACTIVE = 6;
    localparam int ABU_BIT_WAIT_EXIT = 1;
    localparam int ABU_BIT_CLEAR_PERMIT = 7;
    localparam logic [7:0] ABU_RESET_BYTE = 8'h00;
    localparam logic [15:0] ABU_VEC_USER = 16'hFFFC;
    localparam logic [15:0] ABU_VEC_MONITOR = 16'hFEFC;
endpackage

// >>> rtl/abu_addr_cmp.sv
// Sixteen-bit breakpoint address comparator
`timescale 1ns/1ps
module abu_addr_cmp
    import abu_pkg::*;
(
    input wire logic [7:0] i_high,
    input wire logic [7:0] i_low,
    input wire logic [15:0] i_addr,
    input wire logic i_valid,
    output logic o_match
);
    // One compare per bus cycle, qualified by a new CPU address
    assign o_match = i_valid && (i_addr == {i_high, i_low});
endmodule // abu_addr_cmp

// >>> rtl/abu_break_unit.sv
// Address breakpoint unit: registers, match, break state and side controls
// How it works
// - With the enable bit set a break is flagged on a full 16-bit address match, otherwise not.
// - The enable bit is bit 7 of the status and control register, read/write, cleared by zero.
// - The break-active bit is set by hardware on an enabled match and reads one while set.
// - Writing one to the break-active bit requests a break without any address match.
// - After clearing break-active with an unchanged address, that same address raises no break.
// - Two byte registers hold the breakpoint address halves, read/write, reset to zero.
// - The clear-permit bit lets status bits be cleared during break, else they are kept.
// - The timer counter is halted for as long as the break state lasts.
// - The watchdog is held off during break while test high voltage is on the reset pin.
// - The wait-exit flag reads one when wait mode was ended by a break, else zero.
// - The wait-exit register only works in emulation mode.
// - In wait and stop the unit stays enabled but raises no address-match break.
// - A match asserts the breakpoint signal and the vector follows the normal or monitor pair.
// - Opcode breaks precede the instruction, operand breaks follow it, software breaks wait.
// - Writing zero to the wait-exit flag clears it; reset clears it too.
//
// The plain strobed port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module abu_break_unit
    import abu_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    input wire logic [15:0] i_cpu_addr,
    input wire logic i_cpu_addr_valid,
    input wire logic i_cpu_opcode_fetch,
    input wire logic i_instr_boundary,
    input wire logic i_break_state,
    input wire logic i_wait_mode,
    input wire logic i_stop_mode,
    input wire logic i_monitor_mode,
    input wire logic i_emulation_mode,
    input wire logic i_test_high_voltage,
    output logic o_breakpoint_signal,
    output logic o_suppress_instr,
    output logic [15:0] o_break_vector,
    output logic o_status_clear_permit,
    output logic o_timer_halt,
    output logic o_watchdog_disable
);
    logic enable_reg;
    logic active_reg;
    logic [7:0] addr_high_reg;
    logic [7:0] addr_low_reg;
    logic permit_reg;
    logic wait_exit_reg;
    logic sw_req_reg;
    logic breakpoint_signal_reg;
    logic suppress_reg;
    logic [7:0] rdata_reg;
    logic rearm_reg;
    logic raw_match;
    logic hit;
    logic wr_ctrl;
    logic wr_high;
    logic wr_low;

    assign wr_ctrl = i_wr && (i_addr == ABU_OFF_STATUS_CTRL);
    assign wr_high = i_wr && (i_addr == ABU_OFF_ADDR_HIGH);
    assign wr_low = i_wr && (i_addr == ABU_OFF_ADDR_LOW);

    abu_addr_cmp u_cmp
    (
        .i_high(addr_high_reg),
        .i_low(addr_low_reg),
        .i_addr(i_cpu_addr),
        .i_valid(i_cpu_addr_valid),
        .o_match(raw_match)
    );

    // A disarmed address stays silent until either byte is rewritten
    // Address bus frozen in wait or stop, so no match there
    assign hit = enable_reg && raw_match && rearm_reg && !i_wait_mode && !i_stop_mode;

    // Enable bit
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
            enable_reg <= 1'b0;
        else if (wr_ctrl)
            enable_reg <= i_wdata[ABU_BIT_ENABLE];
    end

    // Break-active: hardware set wins over a software clear
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
            active_reg <= 1'b0;
        else if (hit)
            active_reg <= 1'b1;
        else if (wr_ctrl)
            active_reg <= i_wdata[ABU_BIT_ACTIVE];
    end

    // Clearing active with the address untouched disarms that same address
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
            rearm_reg <= 1'b1;
        else if (wr_high || wr_low)
            rearm_reg <= 1'b1;
        else if (wr_ctrl && !i_wdata[ABU_BIT_ACTIVE] && active_reg && !hit)
            rearm_reg <= 1'b0;
    end

    // Software break waits for the next instruction boundary
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
            sw_req_reg <= 1'b0;
        else if (wr_ctrl && i_wdata[ABU_BIT_ACTIVE])
            sw_req_reg <= 1'b1;
        else if (i_instr_boundary)
            sw_req_reg <= 1'b0;
    end

    // Breakpoint pulse to the system integration unit
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
            breakpoint_signal_reg <= 1'b0;
        else
            breakpoint_signal_reg <= hit || (sw_req_reg && i_instr_boundary);
    end

    // Opcode hits block the instruction; operand hits let it finish
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
            suppress_reg <= 1'b0;
        else
            suppress_reg <= hit && i_cpu_opcode_fetch;
    end

    // Address halves
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            addr_high_reg <= ABU_RESET_BYTE;
            addr_low_reg <= ABU_RESET_BYTE;
        end
        else
        begin
            if (wr_high)
                addr_high_reg <= i_wdata;
            if (wr_low)
                addr_low_reg <= i_wdata;
        end
    end

    // Flag clear permit
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
            permit_reg <= 1'b0;
        else if (i_wr && (i_addr == ABU_OFF_FLAG_CLEAR))
            permit_reg <= i_wdata[ABU_BIT_CLEAR_PERMIT];
    end

    // Wait-exit flag: set on a break leaving wait, only in emulation mode
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
            wait_exit_reg <= 1'b0;
        else if (i_emulation_mode && i_wait_mode && i_break_state)
            wait_exit_reg <= 1'b1;
        else if (i_emulation_mode && i_wr && (i_addr == ABU_OFF_WAIT_STATUS)
                 && !i_wdata[ABU_BIT_WAIT_EXIT])
            wait_exit_reg <= 1'b0;
    end

    // Read data, one cycle after the strobe
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
            rdata_reg <= 8'h00;
        else if (i_rd)
        begin
            case (i_addr)
                ABU_OFF_STATUS_CTRL: rdata_reg <= {enable_reg, active_reg, 6'h00};
                ABU_OFF_ADDR_HIGH: rdata_reg <= addr_high_reg;
                ABU_OFF_ADDR_LOW: rdata_reg <= addr_low_reg;
                ABU_OFF_FLAG_CLEAR: rdata_reg <= {permit_reg, 7'h00};
                ABU_OFF_WAIT_STATUS: rdata_reg <= {6'h00, wait_exit_reg & i_emulation_mode,
                                                   1'b0};
                default: rdata_reg <= 8'h00;
            endcase
        end
        else
            rdata_reg <= 8'h00;
    end

    assign o_rdata = rdata_reg;
    assign o_breakpoint_signal = breakpoint_signal_reg;
    assign o_suppress_instr = suppress_reg;
    assign o_break_vector = i_monitor_mode ? ABU_VEC_MONITOR : ABU_VEC_USER;
    // Outside break state clearing is never blocked
    assign o_status_clear_permit = !i_break_state || permit_reg;
    assign o_timer_halt = i_break_state;
    assign o_watchdog_disable = i_break_state && i_test_high_voltage;

    // Break path checks
    a_match_raises_breakpoint_signal: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        hit |=> o_breakpoint_signal && active_reg)
        else $error("enabled match did not raise break");
    a_disabled_no_set: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (!enable_reg && !wr_ctrl && !active_reg) |=> !active_reg)
        else $error("active set while disabled");
    a_enable_write: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        wr_ctrl |=> enable_reg == $past(i_wdata[ABU_BIT_ENABLE]))
        else $error("enable bit not written");
    sequence s_sw_write;
        wr_ctrl && i_wdata[ABU_BIT_ACTIVE];
    endsequence
    sequence s_boundary;
        i_instr_boundary;
    endsequence
    sequence s_no_boundary;
        !i_instr_boundary;
    endsequence
    // Request held over a quiet cycle, then taken at the next boundary
    a_sw_break: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        s_sw_write ##1 s_no_boundary ##1 s_boundary |=> o_breakpoint_signal)
        else $error("software break missing");
    a_sw_sets_active: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (wr_ctrl && i_wdata[ABU_BIT_ACTIVE]) |=> active_reg)
        else $error("software break not flagged active");
    a_active_clear: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (wr_ctrl && !i_wdata[ABU_BIT_ACTIVE] && !hit) |=> !active_reg)
        else $error("break-active not cleared");
    // Checked at the pulse itself, not at the internal hit term
    a_lowpower_quiet: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        ((i_wait_mode || i_stop_mode) && !(sw_req_reg && i_instr_boundary))
        |=> !o_breakpoint_signal)
        else $error("break raised during low power");
    a_disarm_same: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (wr_ctrl && !i_wdata[ABU_BIT_ACTIVE] && active_reg && !hit) ##1
        (!wr_high && !wr_low) |-> !hit)
        else $error("rebroke on same address");
    a_addr_read: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (i_rd && i_addr == ABU_OFF_ADDR_HIGH) |=> o_rdata == $past(addr_high_reg))
        else $error("high byte readback wrong");
    a_addr_low_read: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (i_rd && i_addr == ABU_OFF_ADDR_LOW) |=> o_rdata == $past(addr_low_reg))
        else $error("low byte readback wrong");
    a_rearm_write: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (wr_high || wr_low) |=> rearm_reg)
        else $error("address write did not rearm");

    // Full-width compare written apart from the comparator instance
    a_cmp_full: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (enable_reg && rearm_reg && i_cpu_addr_valid && !i_wait_mode && !i_stop_mode
        && i_cpu_addr == {addr_high_reg, addr_low_reg}) |-> hit)
        else $error("full address match missed");
    a_opcode_blocked: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (hit && i_cpu_opcode_fetch) |=> o_suppress_instr)
        else $error("opcode hit not suppressed");
    a_operand_runs: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (hit && !i_cpu_opcode_fetch) |=> !o_suppress_instr)
        else $error("operand hit suppressed");

    // Vector pair follows monitor mode
    a_vector_user: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        !i_monitor_mode |-> o_break_vector == ABU_VEC_USER)
        else $error("user vector wrong");
    a_vector_monitor: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        i_monitor_mode |-> o_break_vector == ABU_VEC_MONITOR)
        else $error("monitor vector wrong");
    a_timer_halt: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        o_timer_halt == i_break_state)
        else $error("timer not halted in break");
    a_watchdog_off: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (i_break_state && i_test_high_voltage) |-> o_watchdog_disable)
        else $error("watchdog running in break");
    a_watchdog_kept: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        !i_test_high_voltage |-> !o_watchdog_disable)
        else $error("watchdog off without test voltage");
    a_permit_gate: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (i_break_state && !permit_reg) |-> !o_status_clear_permit)
        else $error("clear allowed without permit");
    a_permit_open: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        !i_break_state |-> o_status_clear_permit)
        else $error("clearing blocked outside break");

    // Wait-exit flag, emulation mode only
    a_wait_exit_set: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (i_emulation_mode && i_wait_mode && i_break_state) |=> wait_exit_reg)
        else $error("wait exit not flagged");
    a_wait_exit_clear: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (i_emulation_mode && i_wr && i_addr == ABU_OFF_WAIT_STATUS
        && !i_wdata[ABU_BIT_WAIT_EXIT] && !(i_wait_mode && i_break_state)) |=> !wait_exit_reg)
        else $error("wait exit not cleared");
    a_wait_exit_gate: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (i_rd && i_addr == ABU_OFF_WAIT_STATUS && !i_emulation_mode) |=> o_rdata == 8'h00)
        else $error("wait status visible outside emulation");
endmodule // abu_break_unit

// >>> bench/abu_cpu_model.sv
// Behavioural CPU and system integration model: tracks the break state
`timescale 1ns/1ps
module abu_cpu_model
(
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    input wire logic i_breakpoint_signal,
    input wire logic i_rti,
    output logic o_break_state
);
    // Return from interrupt only ends the state; a new request wins
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
            o_break_state <= 1'b0;
        else if (i_breakpoint_signal)
            o_break_state <= 1'b1;
        else if (i_rti)
            o_break_state <= 1'b0;
    end
endmodule // abu_cpu_model

// >>> bench/tb.sv
// Self-checking bench for the address breakpoint unit
`timescale 1ns/1ps
module tb
    import abu_pkg::*;
;
    logic clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, vld = 1'b0, opc = 1'b0;
    logic bnd = 1'b0, wt = 1'b0, stp = 1'b0, mon = 1'b0, emu = 1'b0, tv = 1'b0;
    logic rti = 1'b0;
    logic brk, bp, sup, perm, th, wdd;
    logic [7:0] adr = 8'h00, wd = 8'h00, rdat;
    logic [15:0] ca = 16'h0000, vec, t16;
    logic [7:0] offs [6] = '{ABU_OFF_WAIT_STATUS, ABU_OFF_FLAG_CLEAR, ABU_OFF_ADDR_HIGH,
        ABU_OFF_ADDR_LOW, ABU_OFF_STATUS_CTRL, 8'h05};
    int err_total = 0, n_checks = 0, n_bp = 0, n_sup = 0, i;
    integer seed = 32'h37d2fa5f;
    always #12.5 clk = ~clk;
    abu_break_unit DUT (.i_clk_sys(clk), .i_nrst(nrst), .i_addr(adr), .i_wdata(wd),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdat), .i_cpu_addr(ca), .i_cpu_addr_valid(vld),
        .i_cpu_opcode_fetch(opc), .i_instr_boundary(bnd), .i_break_state(brk),
        .i_wait_mode(wt), .i_stop_mode(stp), .i_monitor_mode(mon), .i_emulation_mode(emu),
        .i_test_high_voltage(tv), .o_breakpoint_signal(bp), .o_suppress_instr(sup),
        .o_break_vector(vec), .o_status_clear_permit(perm), .o_timer_halt(th),
        .o_watchdog_disable(wdd));
    abu_cpu_model u_cpu (.i_clk_sys(clk), .i_nrst(nrst), .i_breakpoint_signal(bp),
        .i_rti(rti), .o_break_state(brk));
    // Pulses last one cycle, so count them rather than poll
    always @(posedge clk)
    begin
        n_bp += (bp === 1'b1);
        n_sup += (sup === 1'b1);
    end
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic give_verdict();
        if (err_total == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        adr <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // Data stands only in the cycle after the strobe
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        adr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk($sformatf("rdata_%h", a), {8'h00, rdat}, {8'h00, e});
    endtask
    task automatic fetch(input logic [15:0] a, input logic o);
        @(posedge clk);
        ca <= a;
        vld <= 1'b1;
        opc <= o;
        bnd <= o;
        @(posedge clk);
        vld <= 1'b0;
        bnd <= 1'b0;
        ca <= 16'($random(seed));
        repeat (3) @(posedge clk);
    endtask
    task automatic ret();
        @(posedge clk);
        rti <= 1'b1;
        @(posedge clk);
        rti <= 1'b0;
        #1;
    endtask
    initial
    begin
        #200us;
        err_total++;
        give_verdict();
    end
    initial
    begin
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        for (i = 0; i < 6; i++)
            rdc(offs[i], 8'h00);
        for (i = 0; i < 4; i++)
        begin
            t16 = 16'($random(seed));
            wr_reg(ABU_OFF_ADDR_HIGH, t16[15:8]);
            wr_reg(ABU_OFF_ADDR_LOW, t16[7:0]);
            rdc(ABU_OFF_ADDR_HIGH, t16[15:8]);
            rdc(ABU_OFF_ADDR_LOW, t16[7:0]);
            fetch(t16, 1'b1);
        end
        chk("disabled_breaks", 16'(n_bp), 16'd0);
        chk("permit_idle", {15'h0, perm}, 16'h0001);
        chk("timer_idle", {15'h0, th}, 16'h0000);
        wr_reg(ABU_OFF_STATUS_CTRL, 8'h80);
        rdc(ABU_OFF_STATUS_CTRL, 8'h80);
        fetch(t16 ^ 16'h0100, 1'b1);
        fetch(t16 ^ 16'h0001, 1'b1);
        chk("near_miss", 16'(n_bp), 16'd0);
        fetch(t16, 1'b1);
        chk("hit_pulses", 16'(n_bp), 16'd1);
        chk("suppress", 16'(n_sup), 16'd1);
        rdc(ABU_OFF_STATUS_CTRL, 8'hC0);
        chk("timer_halt", {15'h0, th}, 16'h0001);
        chk("vector", vec, ABU_VEC_USER);
        chk("permit", {15'h0, perm}, 16'h0000);
        chk("watchdog", {15'h0, wdd}, 16'h0000);
        mon <= 1'b1;
        tv <= 1'b1;
        wr_reg(ABU_OFF_FLAG_CLEAR, 8'h80);
        rdc(ABU_OFF_FLAG_CLEAR, 8'h80);
        chk("permit", {15'h0, perm}, 16'h0001);
        chk("watchdog", {15'h0, wdd}, 16'h0001);
        chk("vector", vec, ABU_VEC_MONITOR);
        mon <= 1'b0;
        tv <= 1'b0;
        wr_reg(ABU_OFF_FLAG_CLEAR, 8'h00);
        wr_reg(ABU_OFF_STATUS_CTRL, 8'h80);
        ret();
        chk("timer_halt", {15'h0, th}, 16'h0000);
        chk("permit_after", {15'h0, perm}, 16'h0001);
        fetch(t16, 1'b1);
        chk("disarmed", 16'(n_bp), 16'd1);
        // A byte write rearms; operand hit must not suppress
        wr_reg(ABU_OFF_ADDR_LOW, t16[7:0]);
        fetch(t16, 1'b0);
        chk("rearmed", 16'(n_bp), 16'd2);
        chk("suppress", 16'(n_sup), 16'd1);
        wr_reg(ABU_OFF_STATUS_CTRL, 8'h80);
        ret();
        for (i = 0; i < 2; i++)
        begin
            wt <= (i == 0);
            stp <= (i == 1);
            wr_reg(ABU_OFF_ADDR_LOW, t16[7:0]);
            fetch(t16, 1'b1);
        end
        chk("low_power", 16'(n_bp), 16'd2);
        rdc(ABU_OFF_STATUS_CTRL, 8'h80);
        wt <= 1'b0;
        stp <= 1'b0;
        wr_reg(ABU_OFF_STATUS_CTRL, 8'hC0);
        fetch(~t16, 1'b1);
        chk("soft_break", 16'(n_bp), 16'd3);
        wt <= 1'b1;
        rdc(ABU_OFF_WAIT_STATUS, 8'h00);
        emu <= 1'b1;
        repeat (2) @(posedge clk);
        wt <= 1'b0;
        rdc(ABU_OFF_WAIT_STATUS, 8'h02);
        wr_reg(ABU_OFF_WAIT_STATUS, 8'h00);
        rdc(ABU_OFF_WAIT_STATUS, 8'h00);
        emu <= 1'b0;
        wr_reg(ABU_OFF_STATUS_CTRL, 8'h00);
        ret();
        tv <= 1'b1;
        #1;
        chk("watchdog_idle", {15'h0, wdd}, 16'h0000);
        tv <= 1'b0;
        // Second reset in mid-run must clear the address bytes again
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        rdc(ABU_OFF_ADDR_LOW, 8'h00);
        rdc(ABU_OFF_ADDR_HIGH, 8'h00);
        rdc(ABU_OFF_STATUS_CTRL, 8'h00);
        give_verdict();
    end
endmodule // tb
